// ==== aof_pkg.sv ====
// Function
// - Channel faults suppressed without terminal block unless enabled
// - Module faults, terminal block loss/add, always generated
// - Fault master enable gates field power, overtemp faults
// - Field power removed fault has own enable
// - Over-temperature fault has own enable
// - Interrupt master and field power enable raise interrupt
// - Interrupt master and overtemp enable raise interrupt
// - Range type three-valued, resets to disabled current
// - Four ranges, default bipolar ten volts
// - Value format integer or float, default float
// - Disabled current drives zero, ignores other settings
// - Disabled voltage drives zero, ignores other settings
// - Hold last state keeps last commanded value
// - Otherwise defaulting drives configured default value
// - Default with ramp enabled ramps gradually
// - Five defaulting conditions including outputs not enabled
// - Bad backplane power steps to default immediately
// - Hot removal while enabled holds last value
// - Service request reset holds; program defaults first
// - First store after power-up steps immediately
// - Kept analog power and same config: unchanged
// - Later reconfigurations apply default ramp rate
// - Field power loss drives zero volts, zero amps
package aof_pkg;
  localparam int NCH = 8;
  localparam logic [7:0] OFF_MODCFG = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [2:0] GRP_CHCFG = 3'h1;
  localparam logic [2:0] GRP_CMD = 3'h2;
  localparam logic [2:0] GRP_DEFV = 3'h3;
  localparam logic [2:0] GRP_OUT = 3'h4;
  localparam int MC_CHFLT_WO_TB = 0;
  localparam int MC_FLT_MASTER = 1;
  localparam int MC_FP_FLT = 2;
  localparam int MC_OT_FLT = 3;
  localparam int MC_IRQ_MASTER = 4;
  localparam int MC_FP_IRQ = 5;
  localparam int MC_OT_IRQ = 6;
  localparam logic [7:0] MODCFG_RST = 8'h0E;
  localparam int CT_STORE = 0;
  localparam int CT_SVC = 1;
  localparam logic [1:0] RT_DIS_V = 2'h0;
  localparam logic [1:0] RT_DIS_I = 2'h1;
  localparam logic [1:0] RT_ACTIVE = 2'h2;
  localparam logic [1:0] RG_BIP10 = 2'h0;
  localparam logic [1:0] RG_UNI10 = 2'h1;
  localparam logic [1:0] RG_4_20 = 2'h2;
  localparam logic [1:0] RG_0_20 = 2'h3;
  localparam logic [31:0] CHCFG_RST = 32'h0000_0001;
  localparam logic [15:0] DEFV_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] FLT_EXP_BIAS = 8'h7F;
  localparam logic [7:0] FLT_EXP_SAT = 8'h8E;
  typedef struct packed {
    logic [15:0] step;
    logic [8:0] rsv;
    logic ramp_en;
    logic hold_last;
    logic fmt_int;
    logic [1:0] range;
    logic [1:0] rtype;
  } aof_chcfg_t;
endpackage

// ==== aof_chan_if.sv ====
interface aof_chan_if;
  logic tick;
  logic zero;
  logic hold_force;
  logic dflt;
  logic immediate;
  aof_pkg::aof_chcfg_t cfg;
  logic [31:0] cmd;
  logic [15:0] defv;
  logic [15:0] code;
  logic ramping;
  modport ctl(output tick, zero, hold_force, dflt, immediate, cfg, cmd, defv,
    input code, ramping);
  modport chan(input tick, zero, hold_force, dflt, immediate, cfg, cmd, defv,
    output code, ramping);
endinterface

// ==== aof_sync.sv ====
module aof_sync #(
  parameter int W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } aof_sync_t;
  aof_sync_t st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    st_next.s1 = i_async;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // Only settled bits move, so a glitch seen for one stage is dropped
    for (int k = 0; k < W; k++) begin
      if (st_reg.s2[k] == st_reg.s3[k]) begin
        st_next.q[k] = st_reg.s3[k];
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign o_sync = st_reg.q;
endmodule

// ==== aof_chan.sv ====
module aof_chan (
  input wire logic i_clk,
  input wire logic i_ana_rst_b,
  aof_chan_if.chan ch
);
  typedef struct packed {
    logic [15:0] value;
    logic ramping;
  } aof_chan_t;
  aof_chan_t st_reg, st_next;
  logic [15:0] target;
  logic use_ramp;
  logic signed [16:0] diff;
  logic signed [16:0] stp;

  function automatic logic [15:0] aof_f2i(input logic [31:0] f);
    logic [15:0] m;
    logic [15:0] r;
    logic [7:0] e;
    m = {1'b1, f[22:8]};
    e = f[30:23] - aof_pkg::FLT_EXP_BIAS;
    r = 16'h0000;
    if (f[30:23] < aof_pkg::FLT_EXP_BIAS) begin
      r = 16'h0000;
    end else if (f[30:23] >= aof_pkg::FLT_EXP_SAT) begin
      r = f[31] ? 16'h8000 : 16'h7FFF;
    end else begin
      r = m >> (4'hF - e[3:0]);
      r = f[31] ? 16'(-r) : r;
    end
    return r;
  endfunction

  always_comb begin
    st_next = st_reg;
    use_ramp = 1'b0;
    target = ch.cfg.fmt_int ? ch.cmd[15:0] : aof_f2i(ch.cmd);
    if (ch.zero || ch.cfg.rtype != aof_pkg::RT_ACTIVE) begin
      target = 16'h0000;
    end else if (ch.hold_force || (ch.dflt && ch.cfg.hold_last)) begin
      target = st_reg.value;
    end else if (ch.dflt) begin
      target = ch.defv;
      use_ramp = ch.cfg.ramp_en && !ch.immediate;
    end
    diff = 17'(signed'(target)) - 17'(signed'(st_reg.value));
    stp = 17'({1'b0, ch.cfg.step});
    if (ch.tick) begin
      st_next.ramping = 1'b0;
      if (!use_ramp || diff <= stp && diff >= -stp) begin
        st_next.value = target;
      end else begin
        st_next.ramping = 1'b1;
        st_next.value = diff > 0 ? 16'(st_reg.value + ch.cfg.step)
          : 16'(st_reg.value - ch.cfg.step);
      end
    end
  end

  // Analog side keeps its own reset so a backplane cycle leaves outputs alone
  always_ff @(posedge i_clk or negedge i_ana_rst_b) begin
    if (!i_ana_rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign ch.code = st_reg.value;
  assign ch.ramping = st_reg.ramping;

  sequence s_fp_lost;
    ch.tick && ch.zero;
  endsequence
  chk_field_zero: assert property (@(posedge i_clk) disable iff (!i_ana_rst_b)
    s_fp_lost |=> ch.code == 16'h0000)
    else $error("field power loss did not zero output");
  chk_hold_force: assert property (@(posedge i_clk) disable iff (!i_ana_rst_b)
    ch.tick && ch.hold_force && !ch.zero && ch.cfg.rtype == aof_pkg::RT_ACTIVE
    |=> $stable(ch.code))
    else $error("forced hold changed output");
  chk_ramp_step: assert property (@(posedge i_clk) disable iff (!i_ana_rst_b)
    ch.tick && use_ramp |=> (17'(signed'(ch.code)) - 17'(signed'($past(ch.code))) <= $past(stp)
    && 17'(signed'($past(ch.code))) - 17'(signed'(ch.code)) <= $past(stp)))
    else $error("ramp exceeded step");
  chk_step_immed: assert property (@(posedge i_clk) disable iff (!i_ana_rst_b)
    ch.tick && ch.dflt && ch.immediate && !ch.zero && !ch.hold_force
    && !ch.cfg.hold_last && ch.cfg.rtype == aof_pkg::RT_ACTIVE |=> ch.code == $past(ch.defv))
    else $error("immediate default not applied");
  chk_disabled_zero: assert property (@(posedge i_clk) disable iff (!i_ana_rst_b)
    ch.tick && ch.cfg.rtype != aof_pkg::RT_ACTIVE |=> ch.code == 16'h0000)
    else $error("disabled channel not zero");
endmodule

// ==== aof_top.sv ====
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
module aof_top (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ana_rst_b,
  input wire logic i_update_tick,
  input wire logic i_outputs_en,
  input wire logic i_bp_pwr_ok,
  input wire logic i_cpu_comm_ok,
  input wire logic i_io_comm_ok,
  input wire logic i_field_pwr_ok,
  input wire logic i_over_temp,
  input wire logic i_tb_present,
  input wire logic i_hot_remove,
  input wire logic [7:0] i_chan_fault,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [127:0] o_chan_code,
  output logic [7:0] o_chan_zero_v,
  output logic [7:0] o_chan_zero_i,
  output logic [7:0] o_chan_fault,
  output logic o_fp_fault,
  output logic o_ot_fault,
  output logic o_fp_irq,
  output logic o_ot_irq,
  output logic o_tb_loss_fault,
  output logic o_tb_add_fault
);
  typedef struct packed {
    logic [7:0] modcfg;
    aof_pkg::aof_chcfg_t [7:0] chcfg;
    logic [7:0][31:0] cmd;
    logic [7:0][15:0] defv;
    logic first_done;
    logic first_pend;
    logic svc_hold;
    logic tb_prev;
    logic tb_loss;
    logic tb_add;
    logic fp_flt;
    logic ot_flt;
    logic fp_irq;
    logic ot_irq;
    logic [7:0] ch_flt;
    logic [7:0] zero_v;
    logic [7:0] zero_i;
    logic aw_got;
    logic w_got;
    logic awready;
    logic wready;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } aof_top_t;
  aof_top_t st_reg, st_next;

  logic [15:0] pins;
  logic outputs_en;
  logic bp_ok;
  logic cpu_ok;
  logic io_ok;
  logic fp_ok;
  logic ot;
  logic tb;
  logic hot_rm;
  logic [7:0] chf;
  logic dflt;
  logic [7:0] ramping;
  logic [7:0][15:0] code;

  // Every status and fault pin crosses from outside the clock domain; i_update_tick is used unsynchronised
  aof_sync #(.W(16)) u_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async({i_outputs_en, i_bp_pwr_ok, i_cpu_comm_ok, i_io_comm_ok,
      i_field_pwr_ok, i_over_temp, i_tb_present, i_hot_remove, i_chan_fault}),
    .o_sync(pins)
  );
  assign {outputs_en, bp_ok, cpu_ok, io_ok, fp_ok, ot, tb, hot_rm, chf} = pins;

  assign dflt = !outputs_en || !bp_ok || !cpu_ok || !io_ok || !fp_ok;

  aof_chan_if ch_if[aof_pkg::NCH]();
  for (genvar g = 0; g < aof_pkg::NCH; g++) begin : g_ch
    assign ch_if[g].tick = i_update_tick;
    assign ch_if[g].zero = !fp_ok;
    // Hot removal, service reset and the wait for the first store all freeze
    assign ch_if[g].hold_force = (hot_rm && outputs_en) || st_reg.svc_hold
      || !st_reg.first_done;
    assign ch_if[g].dflt = dflt;
    assign ch_if[g].immediate = !bp_ok || st_reg.first_pend;
    assign ch_if[g].cfg = st_reg.chcfg[g];
    assign ch_if[g].cmd = st_reg.cmd[g];
    assign ch_if[g].defv = st_reg.defv[g];
    assign code[g] = ch_if[g].code;
    assign ramping[g] = ch_if[g].ramping;
    aof_chan u_chan (
      .i_clk(i_clk),
      .i_ana_rst_b(i_ana_rst_b),
      .ch(ch_if[g])
    );
  end

  function automatic logic [31:0] aof_merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [2:0] wgrp;
  logic [2:0] widx;
  logic [2:0] rgrp;
  logic [2:0] ridx;
  logic wr_ok;
  logic rd_ok;
  logic store;
  assign wgrp = st_reg.awaddr[7:5];
  assign widx = st_reg.awaddr[4:2];
  assign rgrp = s_axi_araddr[7:5];
  assign ridx = s_axi_araddr[4:2];

  always_comb begin
    st_next = st_reg;
    wr_ok = 1'b0;
    rd_ok = 1'b0;
    store = 1'b0;
    // Write path: address and data may arrive in either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      wr_ok = 1'b1;
      if (st_reg.awaddr[1:0] != 2'h0) begin
        wr_ok = 1'b0;
      end else if (st_reg.awaddr == aof_pkg::OFF_MODCFG) begin
        st_next.modcfg = 8'(aof_merge({24'h0, st_reg.modcfg}, st_reg.wdata,
          st_reg.wstrb));
      end else if (st_reg.awaddr == aof_pkg::OFF_CTRL) begin
        store = st_reg.wstrb[0] && st_reg.wdata[aof_pkg::CT_STORE];
        if (st_reg.wstrb[0] && st_reg.wdata[aof_pkg::CT_SVC]) begin
          st_next.svc_hold = 1'b1;
        end
      end else if (wgrp == aof_pkg::GRP_CHCFG) begin
        st_next.chcfg[widx] = aof_merge(st_reg.chcfg[widx], st_reg.wdata,
          st_reg.wstrb);
      end else if (wgrp == aof_pkg::GRP_CMD) begin
        st_next.cmd[widx] = aof_merge(st_reg.cmd[widx], st_reg.wdata, st_reg.wstrb);
      end else if (wgrp == aof_pkg::GRP_DEFV) begin
        st_next.defv[widx] = 16'(aof_merge({16'h0, st_reg.defv[widx]}, st_reg.wdata,
          st_reg.wstrb));
      end else begin
        wr_ok = 1'b0;
      end
      st_next.bresp = wr_ok ? aof_pkg::RESP_OKAY : aof_pkg::RESP_SLVERR;
    end
    st_next.awready = !st_next.aw_got && !st_next.bvalid;
    st_next.wready = !st_next.w_got && !st_next.bvalid;

    // Configuration store: the first one after reset skips the ramp
    if (i_update_tick) begin
      st_next.first_pend = 1'b0;
    end
    if (store) begin
      // A service reset in the same write as the store wins
      st_next.svc_hold = st_reg.wdata[aof_pkg::CT_SVC];
      st_next.first_done = 1'b1;
      if (!st_reg.first_done) begin
        st_next.first_pend = 1'b1;
      end // Later stores leave first_pend clear, so ramps apply
    end

    // Read path: one cycle from address to data
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      rd_ok = s_axi_araddr[1:0] == 2'h0;
      st_next.rdata = 32'h0000_0000;
      if (!rd_ok) begin
        st_next.rdata = 32'h0000_0000;
      end else if (s_axi_araddr == aof_pkg::OFF_MODCFG) begin
        st_next.rdata = {24'h0, st_reg.modcfg};
      end else if (s_axi_araddr == aof_pkg::OFF_CTRL) begin
        st_next.rdata = 32'h0000_0000;
      end else if (s_axi_araddr == aof_pkg::OFF_STATUS) begin
        st_next.rdata = {8'h0, ramping, st_reg.ch_flt, ot, fp_ok, st_reg.svc_hold,
          st_reg.first_done, st_reg.ot_irq, st_reg.fp_irq, st_reg.ot_flt, st_reg.fp_flt};
      end else if (rgrp == aof_pkg::GRP_CHCFG) begin
        st_next.rdata = st_reg.chcfg[ridx];
      end else if (rgrp == aof_pkg::GRP_CMD) begin
        st_next.rdata = st_reg.cmd[ridx];
      end else if (rgrp == aof_pkg::GRP_DEFV) begin
        st_next.rdata = {16'h0, st_reg.defv[ridx]};
      end else if (rgrp == aof_pkg::GRP_OUT) begin
        st_next.rdata = {16'h0, code[ridx]};
      end else begin
        rd_ok = 1'b0;
      end
      st_next.rresp = rd_ok ? aof_pkg::RESP_OKAY : aof_pkg::RESP_SLVERR;
    end
    st_next.arready = !st_next.rvalid;

    // Fault and interrupt gating
    st_next.fp_flt = !fp_ok && st_reg.modcfg[aof_pkg::MC_FLT_MASTER]
      && st_reg.modcfg[aof_pkg::MC_FP_FLT];
    st_next.ot_flt = ot && st_reg.modcfg[aof_pkg::MC_FLT_MASTER]
      && st_reg.modcfg[aof_pkg::MC_OT_FLT];
    st_next.fp_irq = !fp_ok && st_reg.modcfg[aof_pkg::MC_IRQ_MASTER]
      && st_reg.modcfg[aof_pkg::MC_FP_IRQ];
    st_next.ot_irq = ot && st_reg.modcfg[aof_pkg::MC_IRQ_MASTER]
      && st_reg.modcfg[aof_pkg::MC_OT_IRQ];
    st_next.ch_flt = chf & {8{tb || st_reg.modcfg[aof_pkg::MC_CHFLT_WO_TB]}};
    // Terminal block edges report no matter how channel faults are set
    st_next.tb_prev = tb;
    st_next.tb_loss = st_reg.tb_prev && !tb;
    st_next.tb_add = !st_reg.tb_prev && tb;
    for (int c = 0; c < aof_pkg::NCH; c++) begin
      st_next.zero_v[c] = !fp_ok || st_reg.chcfg[c].rtype == aof_pkg::RT_DIS_V;
      st_next.zero_i[c] = !fp_ok || st_reg.chcfg[c].rtype == aof_pkg::RT_DIS_I;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= '0;
      st_reg.modcfg <= aof_pkg::MODCFG_RST;
      st_reg.chcfg <= {aof_pkg::NCH{aof_pkg::CHCFG_RST}};
      st_reg.defv <= {aof_pkg::NCH{aof_pkg::DEFV_RST}};
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign o_chan_code = code;
  assign o_chan_zero_v = st_reg.zero_v;
  assign o_chan_zero_i = st_reg.zero_i;
  assign o_chan_fault = st_reg.ch_flt;
  assign o_fp_fault = st_reg.fp_flt;
  assign o_ot_fault = st_reg.ot_flt;
  assign o_fp_irq = st_reg.fp_irq;
  assign o_ot_irq = st_reg.ot_irq;
  assign o_tb_loss_fault = st_reg.tb_loss;
  assign o_tb_add_fault = st_reg.tb_add;

  sequence s_fp_gone;
    !fp_ok ##1 !fp_ok;
  endsequence
  sequence s_tb_drop;
    tb ##1 !tb;
  endsequence
  chk_fp_fault_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_fp_gone |=> o_fp_fault == ($past(st_reg.modcfg[aof_pkg::MC_FLT_MASTER])
    && $past(st_reg.modcfg[aof_pkg::MC_FP_FLT])))
    else $error("field power fault gating wrong");
  chk_ot_fault_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_ot_fault |-> $past(ot) && $past(st_reg.modcfg[aof_pkg::MC_FLT_MASTER]))
    else $error("overtemp fault without cause");
  chk_master_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !st_reg.modcfg[aof_pkg::MC_FLT_MASTER] ##1 !st_reg.modcfg[aof_pkg::MC_FLT_MASTER]
    |-> !o_fp_fault && !o_ot_fault)
    else $error("fault reported with master off");
  chk_fp_irq_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_fp_irq |-> $past(!fp_ok) && $past(st_reg.modcfg[aof_pkg::MC_IRQ_MASTER])
    && $past(st_reg.modcfg[aof_pkg::MC_FP_IRQ]))
    else $error("field power interrupt without enables");
  chk_ot_irq_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_ot_irq |-> $past(ot) && $past(st_reg.modcfg[aof_pkg::MC_IRQ_MASTER])
    && $past(st_reg.modcfg[aof_pkg::MC_OT_IRQ]))
    else $error("overtemp interrupt without enables");
  chk_tb_suppress: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !tb && !st_reg.modcfg[aof_pkg::MC_CHFLT_WO_TB] |=> o_chan_fault == 8'h00)
    else $error("channel fault without terminal block");
  chk_tb_loss_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_tb_drop |=> o_tb_loss_fault ##1 !o_tb_loss_fault)
    else $error("terminal block loss not one pulse");
  chk_first_store: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    store && !st_reg.first_done |=> st_reg.first_pend && st_reg.first_done)
    else $error("first store not marked immediate");
  sequence s_tb_rise;
    !tb ##1 tb;
  endsequence
  chk_tb_add_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_tb_rise |=> o_tb_add_fault ##1 !o_tb_add_fault)
    else $error("terminal block add not one pulse");
  chk_fp_zero_out: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !fp_ok |=> o_chan_zero_v == 8'hFF && o_chan_zero_i == 8'hFF)
    else $error("field power loss did not flag zero outputs");
  chk_chan_fault_pass: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    tb || st_reg.modcfg[aof_pkg::MC_CHFLT_WO_TB] |=> o_chan_fault == $past(chf))
    else $error("channel fault not passed through");
  chk_svc_keep: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st_reg.svc_hold && !store |=> st_reg.svc_hold)
    else $error("service hold released without store");
endmodule

// ==== aof_cpu_model.sv ====
module aof_cpu_model (
  input wire logic i_clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // Released payload is inverted so a slave cannot live off stale values
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge i_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_awready) s_axi_awaddr <= ~a;
      if (s_axi_wready) s_axi_wdata <= ~d;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge i_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_arready) s_axi_araddr <= ~a;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ==== tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_rst_b, i_ana_rst_b, i_update_tick, i_over_temp, i_tb_present, i_hot_remove;
  logic i_outputs_en, i_bp_pwr_ok, i_cpu_comm_ok, i_io_comm_ok, i_field_pwr_ok;
  logic [7:0] i_chan_fault, s_axi_awaddr, s_axi_araddr, o_chan_zero_v, o_chan_zero_i, o_chan_fault;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [127:0] o_chan_code;
  logic o_fp_fault, o_ot_fault, o_fp_irq, o_ot_irq, o_tb_loss_fault, o_tb_add_fault;
  logic [4:0] ok;
  int n_fail, compares, n_loss, n_add, k;
  assign {i_outputs_en, i_bp_pwr_ok, i_cpu_comm_ok, i_io_comm_ok, i_field_pwr_ok} = ok;
  aof_top i_dut (.*);
  aof_cpu_model i_cpu (.*);
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (o_tb_loss_fault === 1'b1) n_loss++;
    if (o_tb_add_fault === 1'b1) n_add++;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    i_cpu.wr(a, d, rsp);
    chk("bresp", {30'h0, aof_pkg::RESP_OKAY}, {30'h0, rsp});
  endtask
  // Synchronisers need about four edges, so settle before each update
  task automatic tick(input logic [15:0] e, input string nm);
    repeat (6) @(posedge i_clk);
    i_update_tick <= 1'b1;
    @(posedge i_clk);
    i_update_tick <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk(nm, {16'h0, e}, {16'h0, o_chan_code[15:0]});
  endtask
  task automatic t_regs;
    i_cpu.rd(aof_pkg::OFF_MODCFG, rdv, rsp);
    chk("modcfg", 32'h0000_000E, rdv);
    i_cpu.rd(8'h20, rdv, rsp);
    chk("chcfg0", 32'h0000_0001, rdv);
    i_cpu.rd(8'h10, rdv, rsp);
    chk("unmapped", {30'h0, aof_pkg::RESP_SLVERR}, {30'h0, rsp});
    tick(16'h0000, "dis_i code");
    chk("zero_i", 32'h0000_00FF, {24'h0, o_chan_zero_i});
    chk("zero_v", 32'h0, {24'h0, o_chan_zero_v});
  endtask
  task automatic t_faults;
    logic [7:0] tbl [8];
    logic [7:0] v;
    tbl = '{8'h0E, 8'h0C, 8'h0A, 8'h06, 8'h70, 8'h30, 8'h50, 8'h60};
    ok <= 5'h1E;
    i_over_temp <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      v = tbl[i];
      w(aof_pkg::OFF_MODCFG, {24'h0, v});
      repeat (8) @(posedge i_clk);
      chk("fp_fault", v[1] & v[2], o_fp_fault);
      chk("ot_fault", v[1] & v[3], o_ot_fault);
      chk("fp_irq", v[4] & v[5], o_fp_irq);
      chk("ot_irq", v[4] & v[6], o_ot_irq);
    end
    ok <= 5'h1F;
    i_over_temp <= 1'b0;
  endtask
  task automatic t_tblock;
    w(aof_pkg::OFF_MODCFG, 32'h0000_000E);
    k = n_loss;
    i_chan_fault <= 8'hA5;
    i_tb_present <= 1'b0;
    repeat (10) @(posedge i_clk);
    chk("chan_fault off", 32'h0, {24'h0, o_chan_fault});
    chk("tb loss", k + 1, n_loss);
    w(aof_pkg::OFF_MODCFG, 32'h0000_000F);
    repeat (4) @(posedge i_clk);
    chk("chan_fault on", 32'h0000_00A5, {24'h0, o_chan_fault});
    k = n_add;
    i_tb_present <= 1'b1;
    repeat (10) @(posedge i_clk);
    chk("tb add", k + 1, n_add);
    i_chan_fault <= 8'h00;
  endtask
  task automatic t_dflt;
    w(8'h20, 32'h0000_0012);
    w(8'h60, 32'h0000_0100);
    w(8'h40, 32'h0000_0500);
    w(aof_pkg::OFF_CTRL, 32'h1);
    tick(16'h0500, "int cmd");
    for (int i = 0; i < 5; i++) begin
      ok <= 5'h1F & ~(5'h01 << i);
      tick(i == 0 ? 16'h0000 : 16'h0100, "default");
      if (i == 0) chk("fp zero", 32'h3, {30'h0, o_chan_zero_v[0], o_chan_zero_i[0]});
      ok <= 5'h1F;
      tick(16'h0500, "back");
    end
    w(8'h20, 32'h0000_0032);
    w(aof_pkg::OFF_CTRL, 32'h1);
    ok <= 5'h0F;
    tick(16'h0500, "hold last");
    ok <= 5'h1F;
  endtask
  task automatic t_ramp;
    w(8'h20, 32'h0100_0052);
    w(aof_pkg::OFF_CTRL, 32'h1);
    tick(16'h0500, "cmd");
    ok <= 5'h0F;
    for (int i = 1; i < 6; i++) tick(i < 4 ? 16'h0500 - 16'h0100 * i : 16'h0100, "ramp");
    ok <= 5'h1F;
    tick(16'h0500, "cmd");
    ok <= 5'h17;
    tick(16'h0100, "bp step");
    ok <= 5'h1F;
    tick(16'h0500, "cmd");
  endtask
  task automatic t_hold;
    i_hot_remove <= 1'b1;
    ok <= 5'h1B;
    tick(16'h0500, "hot remove");
    i_hot_remove <= 1'b0;
    tick(16'h0400, "ramp after");
    ok <= 5'h1F;
    tick(16'h0500, "cmd");
    w(aof_pkg::OFF_CTRL, 32'h2);
    ok <= 5'h0F;
    tick(16'h0500, "svc hold");
    w(aof_pkg::OFF_CTRL, 32'h1);
    tick(16'h0400, "later store");
    ok <= 5'h1F;
    tick(16'h0500, "cmd");
  endtask
  task automatic t_power;
    i_rst_b <= 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1'b1;
    chk("kept", 32'h0500, {16'h0, o_chan_code[15:0]});
    w(8'h20, 32'h0100_0052);
    w(8'h60, 32'h0000_0100);
    w(8'h40, 32'h0000_0500);
    tick(16'h0500, "same cfg");
    ok <= 5'h0F;
    w(aof_pkg::OFF_CTRL, 32'h1);
    tick(16'h0100, "first store");
  endtask
  task automatic t_types;
    ok <= 5'h1F;
    for (int i = 0; i < 2; i++) begin
      w(8'h20, i);
      w(aof_pkg::OFF_CTRL, 32'h1);
      tick(16'h0000, "disabled");
      chk("zero vi", i ? 32'h1 : 32'h2, {30'h0, o_chan_zero_v[0], o_chan_zero_i[0]});
    end
    w(8'h20, 32'h0000_0002);
    w(8'h40, 32'h4120_0000);
    w(aof_pkg::OFF_CTRL, 32'h1);
    tick(16'h000A, "float");
    i_cpu.rd(8'h80, rdv, rsp);
    chk("out reg", 32'h0000_000A, rdv);
    i_cpu.rd(aof_pkg::OFF_STATUS, rdv, rsp);
    chk("status", 32'h0000_0050, rdv);
    chk("other chans", 32'h0, {31'h0, |o_chan_code[127:16]});
  endtask
  initial begin
    {n_fail, compares, n_loss, n_add} = '0;
    {i_rst_b, i_ana_rst_b, i_update_tick, i_over_temp, i_hot_remove} = '0;
    i_tb_present = 1'b1;
    i_chan_fault = 8'h00;
    ok = 5'h1F;
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1'b1;
    i_ana_rst_b <= 1'b1;
    t_regs;
    t_faults;
    t_tblock;
    t_dflt;
    t_ramp;
    t_hold;
    t_power;
    t_types;
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    report_and_stop;
  end
endmodule
